/* verilog/sss_pkg.sv */
// Purpose: shared constants for the start-up enable and soft-start sequencer
// Assumes: 10 MHz system clock, APB register access with 32-bit data
// Notes: times are kept in their own units; cycle counts are derived from them
package sss_pkg;

  // clock
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_PERIOD_NS = 100;

  // fixed delays, as printed, and their cycle counts (least times round up)
  localparam int INIT_DELAY_NS = 1_400_000;
  localparam int INIT_DELAY_CYC = (INIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_US = 85;
  localparam int HOLD_CYC = (HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VALID_NS = 500;
  localparam int VALID_CYC = (VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWROK_DELAY_US = 440;
  localparam int PWROK_DELAY_CYC = (PWROK_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // reference stepping: 6.25 mV per step, default 330 kHz step rate
  localparam int STEP_UV = 6250;
  localparam int BOOT_UV = 1_100_000;
  localparam int DEF_STEP_HZ = 330_000;
  localparam int DEF_STEP_CYC = CLK_HZ / DEF_STEP_HZ;
  localparam int DAC_W = 9;
  localparam logic [8:0] BOOT_LEVEL = 9'(BOOT_UV / STEP_UV);
  localparam int TMR_W = 16;

  // voltage code
  localparam int CODE_W = 8;
  localparam logic [4:0] NOLOAD_CODE = 5'h1F;

  // register byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_RAMPDIV = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQSTAT = 8'h0C;
  localparam logic [7:0] OFS_IRQMASK = 8'h10;

  // config fields and reset values
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_PHASE_LSB = 2;
  localparam logic [1:0] CFG_MODE_RST = 2'h0;
  localparam logic [1:0] CFG_PHASE_RST = 2'h0;
  localparam logic [7:0] RAMPDIV_RST = 8'h1D;

  // status fields
  localparam int STAT_DAC_LSB = 8;
  localparam int STAT_PIN_LSB = 20;

  // interrupt bits
  localparam int IRQ_W = 4;
  localparam int IRQ_START = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_SHUT = 2;
  localparam int IRQ_CODEWAIT = 3;

  // table modes and phase counts
  typedef enum logic [1:0] {
    SSS_TWO_STAGE = 2'h0,
    SSS_SIX_BIT = 2'h1,
    SSS_FIVE_BIT = 2'h2
  } sss_mode_t;

  typedef enum logic [1:0] {
    SSS_PH4 = 2'h0,
    SSS_PH2 = 2'h2,
    SSS_PH3 = 2'h3
  } sss_phase_t;

  // sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_SHUT = 7'h01,
    ST_DELAY = 7'h02,
    ST_BOOTRAMP = 7'h04,
    ST_HOLD = 7'h08,
    ST_FINALRAMP = 7'h10,
    ST_PWROKDLY = 7'h20,
    ST_RUN = 7'h40
  } sss_state_t;

endpackage

/* verilog/sss_seq.sv */
// Purpose: start-up enable gating and digital soft-start of a multiphase regulator controller
// Assumes: one 10 MHz clock, synchronous active-high reset, comparator and strap inputs asynchronous
// Notes: APB slave with no wait states; voltage code level arrives already translated to DAC steps
//
// Summary of operation
// - shutdown keeps all PWM outputs high-impedance
// - logic supply reset must be released
// - enable comparator must report above threshold
// - external driver enable must be above threshold
// - driver supply one, plus two/three for 2-3 phases
// - two-stage and 6-bit modes start immediately
// - 5-bit mode withholds start on no-load code
// - first period is fixed delay, no ramp
// - ramp reference from zero to boot level
// - hold boot level 85us plus code validation
// - read code; only valid code starts ramp
// - step up or down from boot to code
// - ramps move 6.25mV per oscillator step
// - grounded rate pin gives 330kHz steps
// - power ok released after fixed delay
// - power ok low in shutdown and soft-start
`timescale 1ns/100ps

module sss_seq #(
  parameter int INIT_DELAY_CYCLES = sss_pkg::INIT_DELAY_CYC,
  parameter int PWROK_DELAY_CYCLES = sss_pkg::PWROK_DELAY_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // comparator indications, asynchronous
  input wire logic logicPorOk,
  input wire logic enableAbove,
  input wire logic extDriverEnableOk,
  input wire logic [2:0] driverBiasSupplyOk,
  input wire logic rampPinGrounded,
  // voltage code, asynchronous
  input wire logic [sss_pkg::CODE_W-1:0] voltageCode,
  input wire logic voltageCodeValid,
  input wire logic [sss_pkg::DAC_W-1:0] voltageCodeLevel,
  // pwm output enables and reference
  output logic [3:0] pwmOutEn,
  output logic [sss_pkg::DAC_W-1:0] dacLevel,
  // open-drain power ok pin
  input wire logic powerOkOutputIn,
  output logic powerOkOutputOut,
  output logic powerOkOutputOe,
  // interrupt
  output logic irq
);
  import sss_pkg::*;

  localparam int SYNC_W = 1 + 1 + 1 + 3 + 1 + CODE_W + 1 + DAC_W + 1;

  // next ramp level, one step toward the goal
  function automatic logic [DAC_W-1:0] stepToward(input logic [DAC_W-1:0] cur, input logic [DAC_W-1:0] goal);
    if (cur < goal) begin
      stepToward = cur + 9'h001;
    end else if (cur > goal) begin
      stepToward = cur - 9'h001;
    end else begin
      stepToward = cur;
    end
  endfunction

  // register select for an apb address
  function automatic logic isReg(input logic [7:0] addr, input logic [7:0] ofs);
    isReg = (addr == ofs);
  endfunction

  logic [SYNC_W-1:0] syncA_r;
  logic [SYNC_W-1:0] syncB_r;
  logic porOk;
  logic enOk;
  logic extOk;
  logic [2:0] supOk;
  logic pinGnd;
  logic [CODE_W-1:0] code;
  logic codeValid;
  logic [DAC_W-1:0] codeLevel;
  logic pgPin;
  logic [1:0] cfgMode_r;
  logic [1:0] cfgPhase_r;
  logic [7:0] rampDiv_r;
  logic [IRQ_W-1:0] irqStat_r;
  logic [IRQ_W-1:0] irqMask_r;
  logic [IRQ_W-1:0] irqEvt;
  sss_state_t state_r;
  sss_state_t state_nxt;
  logic [TMR_W-1:0] tmr_r;
  logic [2:0] validCnt_r;
  logic [7:0] divCnt_r;
  logic [7:0] divTop;
  logic stepTick;
  logic [DAC_W-1:0] dac_r;
  logic supplyOk;
  logic noLoad;
  logic startOk;
  logic timerDone;
  logic codeReady;
  logic ramping;
  logic [DAC_W-1:0] rampGoal;
  logic apbWrite;
  logic apbSetup;
  logic [31:0] readVal;

  // two-flop synchroniser; only the second stage is read by logic
  always_ff @(posedge clock) begin
    if (rst) begin
      syncA_r <= '0;
      syncB_r <= '0;
    end else begin
      syncA_r <= {logicPorOk, enableAbove, extDriverEnableOk, driverBiasSupplyOk, rampPinGrounded,
                  voltageCode, voltageCodeValid, voltageCodeLevel, powerOkOutputIn};
      syncB_r <= syncA_r;
    end
  end

  assign {porOk, enOk, extOk, supOk, pinGnd, code, codeValid, codeLevel, pgPin} = syncB_r;

  // start gating; comparator hysteresis is already inside each indication
  assign supplyOk = supOk[0] & ((cfgPhase_r == SSS_PH4) | (supOk[1] & supOk[2]));
  assign noLoad = (cfgMode_r == SSS_FIVE_BIT) & (code[4:0] == NOLOAD_CODE);
  assign startOk = porOk & enOk & extOk & supplyOk & ~noLoad;

  assign timerDone = (tmr_r == '0);
  assign codeReady = (validCnt_r == 3'(VALID_CYC));

  // step pacing: default rate when the rate pin is grounded, else software divider
  assign divTop = pinGnd ? 8'(DEF_STEP_CYC - 1) : rampDiv_r;
  assign ramping = (state_r == ST_BOOTRAMP) | (state_r == ST_FINALRAMP);
  assign stepTick = ramping & (divCnt_r == 8'h00);
  assign rampGoal = (state_r == ST_BOOTRAMP) ? BOOT_LEVEL : codeLevel;

  // sequencer next state; any lost start condition drops back to shutdown
  always_comb begin
    state_nxt = state_r;
    if (!startOk) begin
      state_nxt = ST_SHUT;
    end else begin
      unique case (state_r)
        ST_SHUT: begin
          state_nxt = ST_DELAY;
        end
        ST_DELAY: begin
          if (timerDone) begin
            state_nxt = (cfgMode_r == SSS_TWO_STAGE) ? ST_BOOTRAMP : ST_FINALRAMP;
          end
        end
        ST_BOOTRAMP: begin
          if (dac_r == BOOT_LEVEL) begin
            state_nxt = ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (timerDone && codeReady && codeValid) begin
            state_nxt = ST_FINALRAMP;
          end
        end
        ST_FINALRAMP: begin
          if (dac_r == codeLevel) begin
            state_nxt = ST_PWROKDLY;
          end
        end
        ST_PWROKDLY: begin
          if (timerDone) begin
            state_nxt = ST_RUN;
          end
        end
        ST_RUN: begin
          state_nxt = ST_RUN;
        end
        default: begin
          state_nxt = ST_SHUT;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= ST_SHUT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // one timer reloaded on each state entry; counts down to zero
  always_ff @(posedge clock) begin
    if (rst) begin
      tmr_r <= '0;
    end else if (state_nxt != state_r) begin
      if (state_nxt == ST_DELAY) begin
        tmr_r <= TMR_W'(INIT_DELAY_CYCLES - 1);
      end else if (state_nxt == ST_HOLD) begin
        tmr_r <= TMR_W'(HOLD_CYC - 1);
      end else if (state_nxt == ST_PWROKDLY) begin
        tmr_r <= TMR_W'(PWROK_DELAY_CYCLES - 1);
      end else begin
        tmr_r <= '0;
      end
    end else if (!timerDone) begin
      tmr_r <= tmr_r - 16'h0001;
    end
  end

  // code validation after the fixed hold: consecutive valid cycles, restart on any invalid one
  always_ff @(posedge clock) begin
    if (rst) begin
      validCnt_r <= 3'h0;
    end else if (state_r != ST_HOLD || !timerDone || !codeValid) begin
      validCnt_r <= 3'h0;
    end else if (!codeReady) begin
      validCnt_r <= validCnt_r + 3'h1;
    end
  end

  // step divider; restarts outside ramps so the first step is a full period away
  always_ff @(posedge clock) begin
    if (rst) begin
      divCnt_r <= RAMPDIV_RST;
    end else if (!ramping || stepTick) begin
      divCnt_r <= divTop;
    end else begin
      divCnt_r <= divCnt_r - 8'h01;
    end
  end

  // reference level; one 6.25 mV code step per tick, up or down
  always_ff @(posedge clock) begin
    if (rst) begin
      dac_r <= '0;
    end else if (state_nxt == ST_SHUT) begin
      dac_r <= '0;
    end else if (stepTick) begin
      dac_r <= stepToward(dac_r, rampGoal);
    end
  end

  // pin-facing outputs; pwm pins released only outside shutdown
  always_ff @(posedge clock) begin
    if (rst) begin
      pwmOutEn <= 4'h0;
      dacLevel <= '0;
      powerOkOutputOut <= 1'b0;
      powerOkOutputOe <= 1'b1;
    end else begin
      if (state_nxt == ST_SHUT) begin
        pwmOutEn <= 4'h0;
      end else if (cfgPhase_r == SSS_PH2) begin
        pwmOutEn <= 4'h3;
      end else if (cfgPhase_r == SSS_PH3) begin
        pwmOutEn <= 4'h7;
      end else begin
        pwmOutEn <= 4'hF;
      end
      dacLevel <= dac_r;
      powerOkOutputOut <= 1'b0;
      powerOkOutputOe <= (state_r != ST_RUN);
    end
  end

  // interrupt events
  assign irqEvt[IRQ_START] = (state_r == ST_SHUT) & (state_nxt == ST_DELAY);
  assign irqEvt[IRQ_DONE] = (state_r == ST_PWROKDLY) & (state_nxt == ST_RUN);
  assign irqEvt[IRQ_SHUT] = (state_r != ST_SHUT) & (state_nxt == ST_SHUT);
  assign irqEvt[IRQ_CODEWAIT] = (state_r == ST_HOLD) & (tmr_r == 16'h0001) & ~codeValid;

  // apb phases: answer is ready in the first cycle of the access phase
  assign apbSetup = psel & ~penable;
  assign apbWrite = psel & penable & pready & pwrite;

  // configuration registers
  always_ff @(posedge clock) begin
    if (rst) begin
      cfgMode_r <= CFG_MODE_RST;
      cfgPhase_r <= CFG_PHASE_RST;
      rampDiv_r <= RAMPDIV_RST;
      irqMask_r <= '0;
    end else if (apbWrite) begin
      if (isReg(paddr, OFS_CONFIG)) begin
        cfgMode_r <= pwdata[CFG_MODE_LSB +: 2];
        cfgPhase_r <= pwdata[CFG_PHASE_LSB +: 2];
      end
      if (isReg(paddr, OFS_RAMPDIV)) begin
        rampDiv_r <= pwdata[7:0];
      end
      if (isReg(paddr, OFS_IRQMASK)) begin
        irqMask_r <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // sticky status; a new event wins over a write-one clear in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      irqStat_r <= '0;
    end else if (apbWrite && isReg(paddr, OFS_IRQSTAT)) begin
      irqStat_r <= (irqStat_r & ~pwdata[IRQ_W-1:0]) | irqEvt;
    end else begin
      irqStat_r <= irqStat_r | irqEvt;
    end
  end

  // interrupt level from a flop; follows status one cycle later
  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat_r & irqMask_r);
    end
  end

  // read mux
  always_comb begin
    readVal = 32'h0000_0000;
    if (isReg(paddr, OFS_CONFIG)) begin
      readVal[CFG_MODE_LSB +: 2] = cfgMode_r;
      readVal[CFG_PHASE_LSB +: 2] = cfgPhase_r;
    end else if (isReg(paddr, OFS_RAMPDIV)) begin
      readVal[7:0] = rampDiv_r;
    end else if (isReg(paddr, OFS_STATUS)) begin
      readVal[6:0] = state_r;
      readVal[STAT_DAC_LSB +: DAC_W] = dac_r;
      readVal[STAT_PIN_LSB +: 5] = {pgPin, startOk, noLoad, supplyOk, codeValid};
    end else if (isReg(paddr, OFS_IRQSTAT)) begin
      readVal[IRQ_W-1:0] = irqStat_r;
    end else if (isReg(paddr, OFS_IRQMASK)) begin
      readVal[IRQ_W-1:0] = irqMask_r;
    end
  end

  // apb answer registered in the setup cycle; unmapped addresses answer with an error
  always_ff @(posedge clock) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apbSetup) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : readVal;
      pslverr <= ~(isReg(paddr, OFS_CONFIG) | isReg(paddr, OFS_RAMPDIV) | isReg(paddr, OFS_STATUS) |
                   isReg(paddr, OFS_IRQSTAT) | isReg(paddr, OFS_IRQMASK));
    end else begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_hold_entry;
    (state_r == ST_BOOTRAMP) ##1 (state_r == ST_HOLD);
  endsequence

  sequence s_final_entry;
    (state_r == ST_HOLD) ##1 (state_r == ST_FINALRAMP);
  endsequence

  a_pwm_hiz_shut: assert property ((state_r == ST_SHUT) |-> pwmOutEn == 4'h0)
    else $error("pwm outputs enabled in shutdown");
  a_por_gate_hold: assert property ((state_r == ST_SHUT && !porOk) |=> state_r == ST_SHUT)
    else $error("left shutdown without logic supply reset release");
  a_en_gate_hold: assert property ((state_r != ST_SHUT && !enOk) |=> state_r == ST_SHUT)
    else $error("enable low did not force shutdown");
  a_ext_gate_hold: assert property ((state_r == ST_SHUT && !extOk) |=> state_r == ST_SHUT)
    else $error("left shutdown without external driver enable");
  a_supply_gate_hold: assert property ((state_r == ST_SHUT && cfgPhase_r != SSS_PH4 && !supOk[2])
                                       |=> state_r == ST_SHUT)
    else $error("left shutdown with third driver supply low");
  a_start_now: assert property ((state_r == ST_SHUT && startOk) |=> state_r == ST_DELAY)
    else $error("start did not follow immediately");
  a_noload_block: assert property ((state_r == ST_SHUT && cfgMode_r == SSS_FIVE_BIT
                                   && code[4:0] == NOLOAD_CODE) |=> state_r == ST_SHUT)
    else $error("five-bit no-load code let soft-start begin");
  a_delay_flat: assert property ((state_r == ST_DELAY) |-> dac_r == '0)
    else $error("reference moved during the first delay");
  a_boot_reach: assert property (s_hold_entry |-> $past(dac_r) == BOOT_LEVEL && dac_r == BOOT_LEVEL)
    else $error("hold entered away from the boot level");
  a_hold_min: assert property ((state_r == ST_HOLD && !timerDone && startOk)
                               |=> state_r == ST_HOLD && dac_r == BOOT_LEVEL)
    else $error("boot hold ended too early");
  a_code_valid_go: assert property (s_final_entry |-> $past(codeValid) && $past(timerDone))
    else $error("final ramp started without valid code");
  a_step_size: assert property ((stepTick && state_nxt != ST_SHUT && dac_r != rampGoal)
                                |=> (dac_r == $past(dac_r) + 9'h001) || (dac_r == $past(dac_r) - 9'h001))
    else $error("reference step was not one code");
  a_step_rate: assert property ((pinGnd && stepTick && ramping) ##1 (ramping && pinGnd)[*8] |-> !stepTick)
    else $error("default step rate too fast");
  a_pwrok_delay: assert property ($rose(state_r == ST_RUN)
                                  |-> $past(state_r) == ST_PWROKDLY && $past(timerDone))
    else $error("power ok released without the fixed delay");
  a_pwrok_low: assert property ((state_r != ST_RUN) |=> powerOkOutputOe)
    else $error("power ok released before soft-start completed");

endmodule // sss_seq

/* testbench/sss_supply_model.sv */
// Purpose: far side of the sequencer: voltage code source and pull-up on the power ok pin
// Assumes: the code-to-level table sits outside the sequencer, level = code + 32 steps
// Notes: a bad code keeps the valid flag low and shows a garbled level
`timescale 1ns/100ps

module sss_supply_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // bench controls
  input wire logic [7:0] codeReq,
  input wire logic codeBad,
  // code pins towards the sequencer
  output logic [7:0] voltageCode,
  output logic voltageCodeValid,
  output logic [8:0] voltageCodeLevel,
  // open-drain power ok pin
  input wire logic powerOkOutputOut,
  input wire logic powerOkOutputOe,
  output logic powerOkOutputIn
);
  logic [1:0] stableCnt;

  // valid only after the code stood still for four edges, as a real decoder would
  always_ff @(posedge clock) begin
    if (rst || codeBad || codeReq != voltageCode) begin
      voltageCode <= codeReq;
      stableCnt <= 2'h0;
      voltageCodeValid <= 1'b0;
    end else if (stableCnt != 2'h3) begin
      stableCnt <= stableCnt + 2'h1;
    end else begin
      voltageCodeValid <= 1'b1;
    end
  end

  // an unvalidated code shows an inverted level, never a usable one
  assign voltageCodeLevel = voltageCodeValid ? 9'(voltageCode) + 9'h020 : ~(9'(voltageCode) + 9'h020);
  // pull-up keeps the pin high unless the sequencer sinks it
  assign powerOkOutputIn = powerOkOutputOe ? powerOkOutputOut : 1'b1;
endmodule // sss_supply_model

/* testbench/testbench.sv */
// Purpose: self-checking bench for the start-up and soft-start sequencer
// Assumes: start and power ok delays shortened to 20 cycles; fixed seed
// Notes: the first step of each ramp is not timed, it lands a full step period after a ramp start not seen on the outputs
`timescale 1ns/100ps

module testbench;
  import sss_pkg::*;
  localparam int INIT_C = 20;
  localparam int PWROK_C = 20;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, irq, rerr;
  logic logicPorOk, enableAbove, extDriverEnableOk, rampPinGrounded, codeBad;
  logic voltageCodeValid, powerOkOutputIn, powerOkOutputOut, powerOkOutputOe;
  logic [2:0] driverBiasSupplyOk;
  logic [3:0] pwmOutEn;
  logic [7:0] paddr, codeReq, voltageCode, code;
  logic [8:0] voltageCodeLevel, dacLevel;
  logic [31:0] pwdata, prdata, rd;
  int errCount, nTests, seed, step;
  logic [7:0] regA [4] = '{OFS_CONFIG, OFS_RAMPDIV, OFS_IRQMASK, 8'h14};
  logic [31:0] regE [4] = '{32'h0, 32'h1D, 32'h0, 32'h0};
  logic [5:0] gateV [5] = '{6'h19, 6'h29, 6'h31, 6'h38, 6'h3B};

  sss_seq #(.INIT_DELAY_CYCLES(INIT_C), .PWROK_DELAY_CYCLES(PWROK_C)) sss_seq_i (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .logicPorOk(logicPorOk),
    .enableAbove(enableAbove), .extDriverEnableOk(extDriverEnableOk), .driverBiasSupplyOk(driverBiasSupplyOk),
    .rampPinGrounded(rampPinGrounded), .voltageCode(voltageCode), .voltageCodeValid(voltageCodeValid),
    .voltageCodeLevel(voltageCodeLevel), .pwmOutEn(pwmOutEn), .dacLevel(dacLevel),
    .powerOkOutputIn(powerOkOutputIn), .powerOkOutputOut(powerOkOutputOut),
    .powerOkOutputOe(powerOkOutputOe), .irq(irq));

  sss_supply_model sss_supply_model_i (.clock(clock), .rst(rst), .codeReq(codeReq), .codeBad(codeBad),
    .voltageCode(voltageCode), .voltageCodeValid(voltageCodeValid), .voltageCodeLevel(voltageCodeLevel),
    .powerOkOutputOut(powerOkOutputOut), .powerOkOutputOe(powerOkOutputOe), .powerOkOutputIn(powerOkOutputIn));

  // 10 MHz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    nTests++;
    if (seen !== exp) begin
      errCount++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic giveVerdict;
    $display("comparisons %0d, mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      errCount++;
      giveVerdict();
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // comparator levels: por, enable, external driver, supplies 2..0
  task automatic setIn(input logic [5:0] v);
    @(posedge clock);
    {logicPorOk, enableAbove, extDriverEnableOk, driverBiasSupplyOk} <= v;
  endtask

  function automatic logic [8:0] expLevel(input logic [7:0] c);
    return 9'(c) + 9'h020;
  endfunction

  // follows one soft-start to run, timing each dac step from the outputs except the first and the one leaving the boot level
  task automatic runSeq(input logic [8:0] t, input int st, input logic boot, input int minEnd, input logic [3:0] pw);
    int c;
    int last;
    logic [8:0] prev;
    c = 0;
    last = 0;
    prev = 9'h000;
    while (powerOkOutputOe !== 1'b0 && c < 40000) begin
      @(posedge clock);
      c++;
      if (dacLevel !== prev) begin
        chk(32'(dacLevel == prev + 9'h001 || prev == dacLevel + 9'h001), 1, "step size");
        if (prev == 9'h000) chk(32'(c > INIT_C), 1, "initial delay");
        if (prev != 9'h000 && prev != BOOT_LEVEL) chk(c - last, st, "step period");
        if (prev == BOOT_LEVEL && boot) chk(32'(c - last >= HOLD_CYC + VALID_CYC && c >= minEnd), 1, "hold");
        prev = dacLevel;
        last = c;
      end
      if (dacLevel !== t) chk(powerOkOutputOe, 1, "power ok low");
    end
    if (c >= 40000) begin
      errCount++;
      giveVerdict();
    end
    chk(dacLevel, t, "final level");
    chk(32'(c - last >= PWROK_C), 1, "power ok delay");
    chk(powerOkOutputIn, 1, "pin released");
    chk(pwmOutEn, pw, "phases on");
  endtask

  // main sequence: corner cases with random codes and step periods
  initial begin
    seed = 32'hE8014BB3;
    errCount = 0;
    nTests = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {logicPorOk, enableAbove, extDriverEnableOk, driverBiasSupplyOk} = 6'h00;
    rampPinGrounded = 1'b1;
    codeBad = 1'b0;
    codeReq = 8'h00;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    chk({pwmOutEn, dacLevel, powerOkOutputOe, irq}, {4'h0, 9'h000, 1'b1, 1'b0}, "reset pins");
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, regA[i], 32'h0);
      chk(rd, regE[i], "reset value");
      chk(rerr, 32'(i == 3), "slave error");
    end
    // a missing por, enable, external driver, first or third driver supply keeps the sequencer shut
    code = 8'($random(seed));
    code[4] = 1'b0;
    codeReq <= code;
    for (int i = 0; i < 5; i++) begin
      if (i == 4) apb(1'b1, OFS_CONFIG, 32'h8);
      setIn(gateV[i]);
      repeat (10) @(posedge clock);
      chk({pwmOutEn, powerOkOutputIn}, 5'h00, "gated");
    end
    apb(1'b1, OFS_CONFIG, 32'h0);
    setIn(6'h39);
    runSeq(expLevel(code), DEF_STEP_CYC, 1'b1, 0, 4'hF);
    // events wait while masked, then raise the interrupt
    chk(irq, 0, "masked irq");
    apb(1'b1, OFS_IRQMASK, 32'hF);
    apb(1'b0, OFS_IRQSTAT, 32'h0);
    chk(rd[1:0], 2'h3, "start and done");
    chk(irq, 1, "irq raised");
    apb(1'b1, OFS_IRQSTAT, 32'hF);
    repeat (2) @(posedge clock);
    chk(irq, 0, "irq cleared");
    // losing the enable in run drops straight to shutdown
    setIn(6'h29);
    repeat (8) @(posedge clock);
    chk({pwmOutEn, dacLevel, powerOkOutputOe, irq}, {4'h0, 9'h000, 1'b1, 1'b1}, "shutdown");
    apb(1'b1, OFS_IRQSTAT, 32'hF);
    // five-bit mode withholds start on the no-load code
    apb(1'b1, OFS_CONFIG, 32'h2);
    codeReq <= {code[7:5], 5'h1F};
    setIn(6'h39);
    repeat (20) @(posedge clock);
    chk(pwmOutEn, 0, "no load");
    step = 2 + ($random(seed) & 7);
    apb(1'b1, OFS_RAMPDIV, 32'(step - 1));
    rampPinGrounded <= 1'b0;
    codeReq <= code;
    runSeq(expLevel(code), step, 1'b0, 0, 4'hF);
    // six-bit mode starts even on that code, three phases
    setIn(6'h00);
    // let the shutdown reach the power ok pin before the next start is followed
    repeat (4) @(posedge clock);
    apb(1'b1, OFS_CONFIG, 32'hD);
    code = {3'($random(seed)), 5'h1F};
    codeReq <= code;
    setIn(6'h3F);
    runSeq(expLevel(code), step, 1'b0, 0, 4'h7);
    // a code that will not validate keeps the boot level beyond the fixed hold
    setIn(6'h00);
    apb(1'b1, OFS_CONFIG, 32'h8);
    apb(1'b1, OFS_IRQSTAT, 32'hF);
    code = 8'($random(seed));
    code[4] = 1'b0;
    codeReq <= code;
    codeBad <= 1'b1;
    // two phases need the second and third driver supplies as well
    setIn(6'h3F);
    fork
      begin
        repeat (3000) @(posedge clock);
        codeBad <= 1'b0;
      end
    join_none
    runSeq(expLevel(code), step, 1'b1, 3000, 4'h3);
    apb(1'b0, OFS_IRQSTAT, 32'h0);
    chk(rd[IRQ_CODEWAIT], 1, "code wait");
    giveVerdict();
  end
endmodule // testbench
